/* File: hw/port_b_mux_pkg.sv */
// constants, register map and decode for the port B alternate function mux
// assumes a 32-bit AXI4-Lite register bus with byte addressing
package port_b_mux_pkg;

    // ------------------------------------------------------------------
    // bus shape
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_PIN_OUTPUT    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PIN_DIRECTION = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PIN_INPUT     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MCU_CONTROL   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PAD_DRIVE     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PAD_PULLUP    = 8'h14;

    // ------------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_PIN_OUTPUT    = 8'h00;
    localparam logic [PORT_W-1:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [PORT_W-1:0] RST_MCU_CONTROL   = 8'h00;
    localparam logic [PORT_W-1:0] MCU_WRITE_MASK    = 8'h93;
    localparam int                MCU_PDIS_BIT      = 4;

    // ------------------------------------------------------------------
    // pin positions of the serial port
    // ------------------------------------------------------------------
    localparam int PIN_SPI_SELECT = 0;

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE      = 3'h0,
        SEL_OUTPUT    = 3'h1,
        SEL_DIRECTION = 3'h2,
        SEL_INPUT     = 3'h3,
        SEL_MCU       = 3'h4,
        SEL_DRIVE     = 3'h5,
        SEL_PULLUP    = 3'h6
    } reg_sel_t;

    // word aligned address to register select
    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        unique case (addr)
            OFF_PIN_OUTPUT:    sel = SEL_OUTPUT;
            OFF_PIN_DIRECTION: sel = SEL_DIRECTION;
            OFF_PIN_INPUT:     sel = SEL_INPUT;
            OFF_MCU_CONTROL:   sel = SEL_MCU;
            OFF_PAD_DRIVE:     sel = SEL_DRIVE;
            OFF_PAD_PULLUP:    sel = SEL_PULLUP;
            default:           sel = SEL_NONE;
        endcase
        return sel;
    endfunction : decode_addr

endpackage : port_b_mux_pkg

/* File: hw/pin_override_cell.sv */
// one pad's override combiner: direction, value, pull-up, input enable
// assumes override terms are generated by the owning peripherals
`timescale 1ns/10ps
`default_nettype none

module pin_override_cell
(
    // port register bits and sleep state
    input  wire logic i_dir,
    input  wire logic i_out,
    input  wire logic i_pdis,
    input  wire logic i_sleep,
    // override terms
    input  wire logic i_pu_fe,
    input  wire logic i_pu_fv,
    input  wire logic i_oe_fe,
    input  wire logic i_oe_fv,
    input  wire logic i_vl_fe,
    input  wire logic i_vl_fv,
    input  wire logic i_ie_fe,
    input  wire logic i_ie_fv,
    // resolved pad controls
    output var  logic o_oe,
    output var  logic o_val,
    output var  logic o_pullup,
    output var  logic o_in_en
);

    // ------------------------------------------------------------------
    // resolution
    // ------------------------------------------------------------------
    wire logic plain_pullup;

    assign plain_pullup = ~i_dir & i_out & ~i_pdis;

    always_comb
    begin
        o_pullup = i_pu_fe ? i_pu_fv : plain_pullup;
        o_oe     = i_oe_fe ? i_oe_fv : i_dir;
        o_val    = i_vl_fe ? i_vl_fv : i_out;
        o_in_en  = i_ie_fe ? i_ie_fv : ~i_sleep;
    end

endmodule : pin_override_cell

`default_nettype wire

/* File: hw/port_b_alternate_function_mux.sv */
// port B pad control with timer, serial port and pin-change overrides
// assumes one clock; all peripheral inputs synchronous to i_clk
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module port_b_alternate_function_mux
(
    // clock and reset
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rst_n,
    // axi4-lite write address
    input  wire logic [port_b_mux_pkg::ADDR_W-1:0]    i_awaddr,
    input  wire logic                                 i_awvalid,
    output var  logic                                 o_awready,
    // axi4-lite write data
    input  wire logic [port_b_mux_pkg::DATA_W-1:0]    i_wdata,
    input  wire logic [port_b_mux_pkg::DATA_W/8-1:0]  i_wstrb,
    input  wire logic                                 i_wvalid,
    output var  logic                                 o_wready,
    // axi4-lite write response
    output var  logic [1:0]                           o_bresp,
    output var  logic                                 o_bvalid,
    input  wire logic                                 i_bready,
    // axi4-lite read address
    input  wire logic [port_b_mux_pkg::ADDR_W-1:0]    i_araddr,
    input  wire logic                                 i_arvalid,
    output var  logic                                 o_arready,
    // axi4-lite read data
    output var  logic [port_b_mux_pkg::DATA_W-1:0]    o_rdata,
    output var  logic [1:0]                           o_rresp,
    output var  logic                                 o_rvalid,
    input  wire logic                                 i_rready,
    // timer compare outputs
    input  wire logic                                 i_timer2_compare_a_en,
    input  wire logic                                 i_timer2_compare_a_out,
    input  wire logic                                 i_timer1_compare_b_en,
    input  wire logic                                 i_timer1_compare_b_out,
    input  wire logic                                 i_timer1_compare_a_en,
    input  wire logic                                 i_timer1_compare_a_out,
    input  wire logic                                 i_timer0_compare_a_en,
    input  wire logic                                 i_timer0_compare_a_out,
    // serial peripheral
    input  wire logic                                 i_serial_peripheral_enable,
    input  wire logic                                 i_serial_controller_select,
    input  wire logic                                 i_spi_target_tx,
    input  wire logic                                 i_spi_ctrl_tx,
    input  wire logic                                 i_spi_sck_out,
    output var  logic                                 o_spi_ctrl_rx,
    output var  logic                                 o_spi_target_rx,
    output var  logic                                 o_spi_sck_in,
    output var  logic                                 o_spi_select_n,
    output var  logic                                 o_spi_target_active,
    // pin change interrupt unit
    input  wire logic [port_b_mux_pkg::PORT_W-1:0]    i_pin_change_mask,
    input  wire logic                                 i_pin_change_group1_enable,
    output var  logic [port_b_mux_pkg::PORT_W-1:0]    o_pin_change_src,
    // sleep controller
    input  wire logic                                 i_sleep,
    // pads
    input  wire logic [port_b_mux_pkg::PORT_W-1:0]    i_pad_in,
    output var  logic [port_b_mux_pkg::PORT_W-1:0]    o_pad_out,
    output var  logic [port_b_mux_pkg::PORT_W-1:0]    o_pad_oe,
    output var  logic [port_b_mux_pkg::PORT_W-1:0]    o_pad_pullup
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [port_b_mux_pkg::PORT_W-1:0]  pin_output_r;
    logic [port_b_mux_pkg::PORT_W-1:0]  pin_direction_r;
    logic [port_b_mux_pkg::PORT_W-1:0]  mcu_control_r;
    logic [port_b_mux_pkg::PORT_W-1:0]  pin_input_r;
    logic [port_b_mux_pkg::ADDR_W-1:0]  awaddr_r;
    logic [port_b_mux_pkg::PORT_W-1:0]  wdata_r;
    logic                               wstrb0_r;
    logic                               aw_have_r;
    logic                               w_have_r;

    wire logic [port_b_mux_pkg::PORT_W-1:0] pu_fe;
    wire logic [port_b_mux_pkg::PORT_W-1:0] pu_fv;
    wire logic [port_b_mux_pkg::PORT_W-1:0] oe_fe;
    wire logic [port_b_mux_pkg::PORT_W-1:0] oe_fv;
    wire logic [port_b_mux_pkg::PORT_W-1:0] vl_fe;
    wire logic [port_b_mux_pkg::PORT_W-1:0] vl_fv;
    wire logic [port_b_mux_pkg::PORT_W-1:0] ie_fe;
    wire logic [port_b_mux_pkg::PORT_W-1:0] ie_fv;
    wire logic [port_b_mux_pkg::PORT_W-1:0] oe_nxt;
    wire logic [port_b_mux_pkg::PORT_W-1:0] val_nxt;
    wire logic [port_b_mux_pkg::PORT_W-1:0] pullup_nxt;
    wire logic [port_b_mux_pkg::PORT_W-1:0] in_en;
    wire logic [port_b_mux_pkg::PORT_W-1:0] pin_input_nxt;

    wire logic                              pdis;
    wire logic                              spi_ctrl;
    wire logic                              spi_target;

    // ------------------------------------------------------------------
    // override terms
    // ------------------------------------------------------------------
    assign pdis       = mcu_control_r[port_b_mux_pkg::MCU_PDIS_BIT];
    assign spi_ctrl   = i_serial_peripheral_enable
                        & i_serial_controller_select;
    assign spi_target = i_serial_peripheral_enable
                        & ~i_serial_controller_select;

    // forced-input pins: 3 in controller mode, 2..0 in target mode
    assign oe_fe[7:4] = 4'h0;
    assign oe_fe[3]   = spi_ctrl;
    assign oe_fe[2]   = spi_target;
    assign oe_fe[1]   = spi_target;
    assign oe_fe[0]   = spi_target;
    assign oe_fv      = 8'h00;

    // forced inputs keep their pull-up, still under global disable
    assign pu_fe      = oe_fe;
    assign pu_fv      = pin_output_r & ~{8{pdis}};

    assign vl_fe[7]   = i_timer2_compare_a_en;
    assign vl_fe[6]   = i_timer1_compare_b_en;
    assign vl_fe[5]   = i_timer1_compare_a_en;
    assign vl_fe[4]   = i_timer0_compare_a_en;
    assign vl_fe[3]   = spi_target;
    assign vl_fe[2]   = spi_ctrl;
    assign vl_fe[1]   = spi_ctrl;
    assign vl_fe[0]   = 1'b0;

    assign vl_fv[7]   = i_timer2_compare_a_out;
    assign vl_fv[6]   = i_timer1_compare_b_out;
    assign vl_fv[5]   = i_timer1_compare_a_out;
    assign vl_fv[4]   = i_timer0_compare_a_out;
    assign vl_fv[3]   = i_spi_target_tx;
    assign vl_fv[2]   = i_spi_ctrl_tx;
    assign vl_fv[1]   = i_spi_sck_out;
    assign vl_fv[0]   = 1'b0;

    // masked pin-change pins stay awake in sleep while group 1 is enabled
    assign ie_fe      = i_pin_change_mask
                        & {8{i_pin_change_group1_enable}};
    assign ie_fv      = 8'hFF;

    // ------------------------------------------------------------------
    // per pin combiners
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < port_b_mux_pkg::PORT_W; gi++)
        begin : g_pin
            pin_override_cell u_cell
            (
                .i_dir    (pin_direction_r[gi]),
                .i_out    (pin_output_r[gi]),
                .i_pdis   (pdis),
                .i_sleep  (i_sleep),
                .i_pu_fe  (pu_fe[gi]),
                .i_pu_fv  (pu_fv[gi]),
                .i_oe_fe  (oe_fe[gi]),
                .i_oe_fv  (oe_fv[gi]),
                .i_vl_fe  (vl_fe[gi]),
                .i_vl_fv  (vl_fv[gi]),
                .i_ie_fe  (ie_fe[gi]),
                .i_ie_fv  (ie_fv[gi]),
                .o_oe     (oe_nxt[gi]),
                .o_val    (val_nxt[gi]),
                .o_pullup (pullup_nxt[gi]),
                .o_in_en  (in_en[gi])
            );
        end
    endgenerate

    // disabled inputs read as zero
    assign pin_input_nxt = i_pad_in & in_en;

    // ------------------------------------------------------------------
    // pad and peripheral outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pad_oe     <= 8'h00;
            o_pad_out    <= 8'h00;
            o_pad_pullup <= 8'h00;
            pin_input_r  <= 8'h00;
        end
        else
        begin
            o_pad_oe     <= oe_nxt;
            o_pad_out    <= val_nxt;
            o_pad_pullup <= pullup_nxt;
            pin_input_r  <= pin_input_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pin_change_src    <= 8'h00;
            o_spi_ctrl_rx       <= 1'b0;
            o_spi_target_rx     <= 1'b0;
            o_spi_sck_in        <= 1'b0;
            o_spi_select_n      <= 1'b1;
            o_spi_target_active <= 1'b0;
        end
        else
        begin
            o_pin_change_src    <= pin_input_nxt;
            o_spi_ctrl_rx       <= pin_input_nxt[3];
            o_spi_target_rx     <= pin_input_nxt[2];
            o_spi_sck_in        <= pin_input_nxt[1];
            o_spi_select_n      <= pin_input_nxt[0];
            o_spi_target_active <= spi_target
                & ~pin_input_nxt[port_b_mux_pkg::PIN_SPI_SELECT];
        end
    end

    // ------------------------------------------------------------------
    // bus write path
    // ------------------------------------------------------------------
    wire port_b_mux_pkg::reg_sel_t wsel;
    wire logic                     aw_take;
    wire logic                     w_take;
    wire logic                     wr_commit;
    wire logic                     b_take;
    wire logic                     wr_en;

    assign aw_take   = i_awvalid & o_awready;
    assign w_take    = i_wvalid & o_wready;
    assign wr_commit = aw_have_r & w_have_r & ~o_bvalid;
    assign b_take    = o_bvalid & i_bready;
    assign wsel      = port_b_mux_pkg::decode_addr(awaddr_r);
    assign wr_en     = wr_commit & wstrb0_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_awready <= 1'b0;
            aw_have_r <= 1'b0;
            awaddr_r  <= '0;
        end
        else if (aw_take)
        begin
            o_awready <= 1'b0;
            aw_have_r <= 1'b1;
            awaddr_r  <= i_awaddr;
        end
        else if (wr_commit)
        begin
            aw_have_r <= 1'b0;
        end
        else if (!aw_have_r && !o_bvalid)
        begin
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_wready <= 1'b0;
            w_have_r <= 1'b0;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
        end
        else if (w_take)
        begin
            o_wready <= 1'b0;
            w_have_r <= 1'b1;
            wdata_r  <= i_wdata[7:0];
            wstrb0_r <= i_wstrb[0];
        end
        else if (wr_commit)
        begin
            w_have_r <= 1'b0;
        end
        else if (!w_have_r && !o_bvalid)
        begin
            o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= port_b_mux_pkg::RESP_OKAY;
        end
        else if (wr_commit)
        begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wsel == port_b_mux_pkg::SEL_NONE)
                        ? port_b_mux_pkg::RESP_SLVERR
                        : port_b_mux_pkg::RESP_OKAY;
        end
        else if (b_take)
        begin
            o_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------
    wire logic [port_b_mux_pkg::PORT_W-1:0] mcu_nxt;

    // read-only bits of the control register stay zero
    assign mcu_nxt = wdata_r & port_b_mux_pkg::MCU_WRITE_MASK;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_output_r    <= port_b_mux_pkg::RST_PIN_OUTPUT;
            pin_direction_r <= port_b_mux_pkg::RST_PIN_DIRECTION;
            mcu_control_r   <= port_b_mux_pkg::RST_MCU_CONTROL;
        end
        else if (wr_en)
        begin
            if (wsel == port_b_mux_pkg::SEL_OUTPUT)
                pin_output_r <= wdata_r;
            if (wsel == port_b_mux_pkg::SEL_DIRECTION)
                pin_direction_r <= wdata_r;
            if (wsel == port_b_mux_pkg::SEL_MCU)
                mcu_control_r <= mcu_nxt;
        end
    end

    // ------------------------------------------------------------------
    // bus read path
    // ------------------------------------------------------------------
    wire port_b_mux_pkg::reg_sel_t          rsel;
    wire logic                              ar_take;
    wire logic [port_b_mux_pkg::PORT_W-1:0] rd_byte;
    wire logic [port_b_mux_pkg::DATA_W-1:0] rd_word;

    assign ar_take = i_arvalid & o_arready;
    assign rsel    = port_b_mux_pkg::decode_addr(i_araddr);
    assign rd_byte =
        (rsel == port_b_mux_pkg::SEL_OUTPUT)    ? pin_output_r    :
        (rsel == port_b_mux_pkg::SEL_DIRECTION) ? pin_direction_r :
        (rsel == port_b_mux_pkg::SEL_INPUT)     ? pin_input_r     :
        (rsel == port_b_mux_pkg::SEL_MCU)       ? mcu_control_r   :
        (rsel == port_b_mux_pkg::SEL_DRIVE)     ? o_pad_oe        :
        (rsel == port_b_mux_pkg::SEL_PULLUP)    ? o_pad_pullup    :
                                                  8'h00;
    assign rd_word = {24'h000000, rd_byte};

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= port_b_mux_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= (rsel == port_b_mux_pkg::SEL_NONE)
                         ? port_b_mux_pkg::RESP_SLVERR
                         : port_b_mux_pkg::RESP_OKAY;
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid  <= 1'b0;
        end
        else if (!o_rvalid)
        begin
            o_arready <= 1'b1;
        end
    end

endmodule : port_b_alternate_function_mux

`default_nettype wire

/* File: verification/periph_model.sv */
// far-side stand-in: timer compare and serial port drive terms
// assumes bench sets enables and phase right after a clock edge
`timescale 1ns/10ps
`default_nettype none
module periph_model
(
    // controls
    input  wire logic       i_clk,
    input  wire logic [3:0] i_tmr_en,
    input  wire logic       i_phase,
    // to the mux
    output var  logic [3:0] o_tmr_en,
    output var  logic [3:0] o_tmr_out,
    output var  logic [2:0] o_spi_tx
);
    // registered like real peripherals
    always_ff @(posedge i_clk)
    begin
        o_tmr_en  <= i_tmr_en;
        o_tmr_out <= {i_phase, ~i_phase, i_phase, ~i_phase};
        o_spi_tx  <= {i_phase, ~i_phase, i_phase};
    end
endmodule : periph_model
`default_nettype wire

/* File: verification/port_b_mux_monitor.sv */
// concurrent checks on the pad and serial outputs of the port mux
// assumes binding into the top module, a single clock domain
`timescale 1ns/10ps
`default_nettype none
module port_b_mux_monitor
(
    // watched inputs
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic [7:0] i_pad_in,
    input wire logic       i_sleep,
    input wire logic [7:0] i_pin_change_mask,
    input wire logic       i_pin_change_group1_enable,
    input wire logic       i_serial_peripheral_enable,
    input wire logic       i_serial_controller_select,
    input wire logic       i_timer2_compare_a_en,
    input wire logic       i_timer2_compare_a_out,
    // watched outputs
    input wire logic [7:0] o_pad_out,
    input wire logic [7:0] o_pad_oe,
    input wire logic [7:0] o_pad_pullup,
    input wire logic [7:0] o_pin_change_src,
    input wire logic       o_spi_ctrl_rx,
    input wire logic       o_spi_target_rx,
    input wire logic       o_spi_target_active
);
    wire logic sen = i_serial_peripheral_enable;
    wire logic ctl = i_serial_controller_select;
    // gated digital input per pin
    wire logic [7:0] g = i_pad_in & ({8{~i_sleep}}
        | (i_pin_change_mask & {8{i_pin_change_group1_enable}}));
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_sel_low;
        sen && !ctl && !g[0];
    endsequence
    sequence s_t2_drive;
        i_timer2_compare_a_en ##1 o_pad_oe[7];
    endsequence
    a_src_gated: assert property ($past(i_rst_n) |->
        o_pin_change_src == $past(g)) else $error("pin change src wrong");
    a_pin7_timer: assert property (s_t2_drive |->
        o_pad_out[7] == $past(i_timer2_compare_a_out)) else $error("pin7");
    a_miso_input: assert property (sen && ctl |=> !o_pad_oe[3])
        else $error("pin3 driven in controller mode");
    a_target_inputs: assert property (sen && !ctl |=>
        o_pad_oe[2:0] == 3'h0) else $error("pins 2..0 driven in target");
    a_target_select: assert property (s_sel_low |=> o_spi_target_active)
        else $error("target not active with select low");
    a_ctrl_rx_path: assert property ($past(i_rst_n) |->
        o_spi_ctrl_rx == $past(g[3])) else $error("controller rx path");
    a_target_rx_path: assert property ($past(i_rst_n) |->
        o_spi_target_rx == $past(g[2])) else $error("target rx path");
    a_pullup_oe_excl: assert property ((o_pad_pullup & o_pad_oe) == 8'h0)
        else $error("pull-up on a driven pin");
endmodule : port_b_mux_monitor
bind port_b_alternate_function_mux port_b_mux_monitor mon
(
    .i_clk, .i_rst_n, .i_pad_in, .i_sleep, .i_pin_change_mask,
    .i_pin_change_group1_enable, .i_serial_peripheral_enable,
    .i_serial_controller_select, .i_timer2_compare_a_en,
    .i_timer2_compare_a_out, .o_pad_out, .o_pad_oe, .o_pad_pullup,
    .o_pin_change_src, .o_spi_ctrl_rx, .o_spi_target_rx, .o_spi_target_active
);
`default_nettype wire

/* File: verification/test_port_b_alternate_function_mux.sv */
// self-checking bench for the port B alternate function mux
// assumes periph_model and the bound monitor are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_port_b_alternate_function_mux;
    localparam logic [7:0] mcu_off = port_b_mux_pkg::OFF_MCU_CONTROL;
    localparam logic [7:0] dir_off = port_b_mux_pkg::OFF_PIN_DIRECTION;
    localparam logic [7:0] out_off = port_b_mux_pkg::OFF_PIN_OUTPUT;
    logic i_clk = '0, i_rst_n = '0, i_awvalid = '0, i_wvalid = '0, ph = '0;
    logic i_bready = '0, i_arvalid = '0, i_rready = '0, i_sleep = '0;
    logic i_serial_peripheral_enable = '0, i_serial_controller_select = '0;
    logic i_pin_change_group1_enable = '0;
    logic [7:0] i_awaddr = '0, i_araddr = '0, i_pin_change_mask = '0;
    logic [7:0] i_pad_in = '0;
    logic [3:0] i_wstrb = 4'hF, tmr_en = '0;
    logic [31:0] i_wdata = '0;
    int bad_count = 0, checked = 0;
    wire logic [3:0] ten, tout;
    wire logic [2:0] stx;
    wire logic [31:0] o_rdata;
    wire logic [7:0] o_pad_out, o_pad_oe, o_pad_pullup, o_pin_change_src;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire logic o_spi_ctrl_rx, o_spi_target_rx, o_spi_target_active;
    wire logic o_spi_sck_in, o_spi_select_n;
    periph_model far (.i_clk, .i_tmr_en(tmr_en), .i_phase(ph),
        .o_tmr_en(ten), .o_tmr_out(tout), .o_spi_tx(stx));
    port_b_alternate_function_mux dut
    (
        .i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready, .i_timer2_compare_a_en(ten[3]),
        .i_timer2_compare_a_out(tout[3]), .i_timer1_compare_b_en(ten[2]),
        .i_timer1_compare_b_out(tout[2]), .i_timer1_compare_a_en(ten[1]),
        .i_timer1_compare_a_out(tout[1]), .i_timer0_compare_a_en(ten[0]),
        .i_timer0_compare_a_out(tout[0]), .i_serial_peripheral_enable,
        .i_serial_controller_select, .i_spi_target_tx(stx[2]),
        .i_spi_ctrl_tx(stx[1]), .i_spi_sck_out(stx[0]), .o_spi_ctrl_rx,
        .o_spi_target_rx, .o_spi_sck_in, .o_spi_select_n,
        .o_spi_target_active, .i_pin_change_mask, .i_pin_change_group1_enable,
        .o_pin_change_src, .i_sleep, .i_pad_in, .o_pad_out, .o_pad_oe,
        .o_pad_pullup
    );
    always #5 i_clk = ~i_clk;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'h7};
        do
        begin
            @(posedge i_clk);
            if (o_awready === 1'h1) i_awvalid <= 1'h0;
            if (o_wready === 1'h1) i_wvalid <= 1'h0;
        end
        while (o_bvalid !== 1'h1);
        chk({6'h0, o_bresp}, 8'h00);
        i_bready <= 1'h0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do
        begin
            @(posedge i_clk);
            if (o_arready === 1'h1) i_arvalid <= 1'h0;
        end
        while (o_rvalid !== 1'h1);
        chk(o_rdata[7:0], e);
        chk({6'h0, o_rresp}, {6'h0, er});
        i_rready <= 1'h0;
        @(posedge i_clk);
    endtask : rd
    // settle, then compare pads
    task automatic pads(input logic [7:0] oe, input logic [7:0] v,
                        input logic [7:0] pu);
        repeat (3) @(posedge i_clk);
        chk(o_pad_oe, oe);
        chk(o_pad_out & o_pad_oe, v);
        chk(o_pad_pullup, pu);
    endtask : pads
    task automatic tally_and_finish;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'h1;
        repeat (2) @(posedge i_clk);
        rd(mcu_off, 8'h00, 2'h0);
        wr(dir_off, 32'hF0);
        wr(out_off, 32'h3C);
        pads(8'hF0, 8'h30, 8'h0C);
        wr(mcu_off, 32'hFF);
        pads(8'hF0, 8'h30, 8'h00);
        rd(mcu_off, 8'h93, 2'h0);
        rd(8'h18, 8'h00, 2'h2);
        wr(mcu_off, 32'h00);
        $display("test registers done");
        {tmr_en, ph} <= 5'h1F;
        pads(8'hF0, 8'hA0, 8'h0C);
        wr(dir_off, 32'h00);
        pads(8'h00, 8'h00, 8'h3C);
        $display("test timers done");
        {i_serial_peripheral_enable, i_serial_controller_select} <= 2'h3;
        i_pad_in <= 8'hFA;
        wr(dir_off, 32'h0F);
        wr(out_off, 32'h0F);
        pads(8'h07, 8'h03, 8'h08);
        chk({6'h0, o_spi_sck_in, o_spi_ctrl_rx}, 8'h03);
        i_serial_controller_select <= 1'h0;
        pads(8'h08, 8'h08, 8'h07);
        chk({7'h0, o_spi_target_rx}, 8'h00);
        chk({6'h0, o_spi_select_n, o_spi_target_active}, 8'h01);
        i_pad_in <= 8'h05;
        pads(8'h08, 8'h08, 8'h07);
        chk({7'h0, o_spi_target_rx}, 8'h01);
        chk({6'h0, o_spi_select_n, o_spi_target_active}, 8'h02);
        $display("test serial done");
        {i_sleep, i_pin_change_group1_enable, i_pin_change_mask} <= 10'h380;
        i_pad_in <= 8'h85;
        pads(8'h08, 8'h08, 8'h07);
        chk(o_pin_change_src, 8'h80);
        i_sleep <= 1'h0;
        pads(8'h08, 8'h08, 8'h07);
        chk(o_pin_change_src, 8'h85);
        $display("test pin change done");
        tally_and_finish();
    end
    // tests need well under 500 cycles
    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
endmodule : test_port_b_alternate_function_mux
`default_nettype wire
